// file: scp_cfg_mem.sv
`timescale 1ns/1ps
module scp_cfg_mem #(
  parameter int               W     = 8,
  parameter int               DEPTH = 8,
  parameter logic [DEPTH-1:0] ONES  = '0
) (
  input  wire logic                     i_mclk,
  input  wire logic                     i_resetn,
  input  wire logic                     i_we,
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input  wire logic [W-1:0]             i_wdata,
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic      [W-1:0]             o_rdata
);

  logic [W-1:0] mem_r [DEPTH];

  if (W < 1 || DEPTH < 2) begin : g_bad_size
    $error("scp_cfg_mem needs a width of one and a depth of two or more");
  end

  // ----------------------------------------------------------------------
  // Storage with per-word reset value
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= ONES[i] ? '1 : '0;
      end
    end else if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem_r[i_raddr];
    end
  end

endmodule : scp_cfg_mem

// file: scp_cmd_port.sv
`timescale 1ns/1ps
// How it works
// RULE1: One 16-bit word each way per frame.
// RULE2: Host frames transfers with chip select low.
// RULE3: Valid word is adopted on select release.
// RULE4: Output released when chip select returns high.
// RULE5: Input bit sampled on serial clock fall.
// RULE6: Next output bit after serial clock rise.
// RULE7: Count clock edges; drop mismatched frames.
// RULE8: Fault flag leads next frame's first bit.
// RULE9: No daisy chain; output only from register.
// RULE10: Ignore bad length, zero mode, forbidden transitions.
// RULE11: Corruption sets error bit and interrupt.
// RULE12: After corruption, repeat previous output data.
// RULE13: Host toggles watchdog bit between frames.
// RULE14: Wake state bit mirrors wake pin level. The code repeats the old wake state bit in a frame after a corrupted one.
// RULE15: Restart request only from software flash mode.
// RULE16: Decode flash, normal, sleep, stop requests.
// RULE17: Fail-safe request only in development mode.
// RULE18: Code 111 reads selected register, writes nothing.
// RULE19: Output mode field reports current mode.
// RULE20: Decode the eight configuration selects.
// RULE21: Restart and init entered automatically only. The code also accepts a restart request by SPI from software flash mode.
// RULE22: Reading the register releases the interrupt.
// RULE23: All interrupt sources enabled after reset.
// RULE24: Discarded frame changes no configuration or mode.
module scp_cmd_port (
  input  wire logic                 i_mclk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_chip_select_n,
  input  wire logic                 i_serial_clk,
  input  wire logic                 i_serial_in,
  output logic                      o_serial_out,
  output logic                      o_serial_out_oe,
  input  wire logic                 i_wake_input,
  input  wire logic                 i_sw_dev_mode,
  input  wire logic                 i_auto_mode_vld,
  input  wire scp_pkg::scp_mode_e   i_auto_mode,
  input  wire scp_pkg::scp_stat_t   i_event_status,
  output logic                      o_cmd_vld,
  output logic                      o_cfg_wr,
  output scp_pkg::scp_cmd_s         o_cmd,
  output logic                      o_watchdog_toggle_bit,
  output scp_pkg::scp_mode_e        o_mode,
  output scp_pkg::scp_cs_e          o_cfg_sel,
  output logic                      o_cmd_err,
  output logic                      o_cmd_err_irq
);
  import scp_pkg::*;

  typedef enum logic {
    FR_IDLE  = 1'b0,
    FR_SHIFT = 1'b1
  } scp_frame_e;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] pins_s;
  logic       sclk_s;
  logic       csn_s;
  logic       sdi_s;
  logic       wake_s;

  scp_sync #(
    .W   (4),
    .RST (PIN_RST)
  ) u_sync (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_async  ({i_serial_clk, i_chip_select_n, i_serial_in, i_wake_input}),
    .o_sync   (pins_s)
  );

  assign sclk_s = pins_s[3];
  assign csn_s  = pins_s[2];
  assign sdi_s  = pins_s[1];
  assign wake_s = pins_s[0];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  scp_frame_e  frame_r;
  logic        sclk_d_r;
  logic        csn_d_r;
  logic [4:0]  fall_cnt_r;
  logic [3:0]  bit_idx_r;
  logic [15:0] in_shift_r;
  scp_rsp_s    out_word_r;
  scp_rsp_s    last_out_r;
  logic        out_bit_r;
  logic        repeat_r;
  logic        fault_r;
  logic        ro_r;
  scp_cs_e     ro_cs_r;
  scp_cs_e     rd_cs_q_r;
  scp_mode_e   mode_r;
  scp_cs_e     cs_sel_r;
  scp_cmd_s    cmd_r;
  logic        cmd_vld_r;
  logic        cfg_wr_r;
  logic        wd_r;
  logic        cmd_err_r;
  logic        fail_en_r;
  logic        irq_r;

  // ----------------------------------------------------------------------
  // Edge and frame decode
  // ----------------------------------------------------------------------
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic       cs_rise;
  logic       in_frame;
  logic       frame_end;
  scp_cmd_s   rx_cmd;
  logic       len_ok;
  logic       req_ok;
  logic       accept;
  logic       corrupt;
  logic       is_read;
  logic       cfg_write;
  logic       err_read;
  logic       hdr_read;
  logic [3:0] nxt_idx;

  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  assign cs_fall   = ~csn_s & csn_d_r;                             // [RULE2]
  assign cs_rise   = csn_s & ~csn_d_r;
  assign in_frame  = (frame_r == FR_SHIFT);
  assign frame_end = in_frame & cs_rise;
  assign rx_cmd    = scp_cmd_s'(in_shift_r);
  assign nxt_idx   = bit_idx_r - 4'h1;

  // Anything but exactly sixteen falling edges is a length error.
  assign len_ok = (fall_cnt_r == BIT_CNT_FULL);                     // [RULE7] [RULE1]

  // Transition filter. Stop may not jump straight into software flash.
  function automatic logic mode_allowed(input scp_mode_e cur,
                                        input scp_mode_e req,
                                        input logic      dev);
    logic ok;
    ok = 1'b1;
    case (req)
      MODE_INIT:     ok = 1'b0;                                      // [RULE10] [RULE21]
      MODE_RESTART:  ok = (cur == MODE_FLASH);                       // [RULE15]
      MODE_FLASH:    ok = (cur != MODE_STOP);                        // [RULE16]
      MODE_FAILSAFE: ok = dev;                                       // [RULE17]
      default:       ok = 1'b1;                                      // [RULE16] [RULE18]
    endcase
    return ok;
  endfunction : mode_allowed

  assign req_ok    = mode_allowed(mode_r, rx_cmd.mode_select_field, i_sw_dev_mode);
  assign accept    = frame_end & len_ok & req_ok;                   // [RULE3] [RULE10]
  assign corrupt   = frame_end & ~accept;                           // [RULE11]
  assign is_read   = (rx_cmd.mode_select_field == MODE_READ);
  // A read access and the reserved select store nothing.
  assign cfg_write = accept & ~is_read &                            // [RULE18] [RULE24]
                     (rx_cmd.config_select_field != CS_RESERVED);   // [RULE20]
  assign err_read  = accept & is_read &
                     (rx_cmd.config_select_field == CS_DEV_FAIL_IRQ);
  // Mode and select are known once the first seven bits are in.
  assign hdr_read  = in_frame & (fall_cnt_r == HDR_BITS) &
                     (in_shift_r[5:3] == MODE_READ);                // [RULE18]

  // ----------------------------------------------------------------------
  // Configuration store and read selection
  // ----------------------------------------------------------------------
  scp_cs_e           rd_addr;
  logic [DATA_W-1:0] mem_rd;
  logic [DATA_W-1:0] fail_stat;
  logic [DATA_W-1:0] sel_data;
  scp_rsp_s          fresh_word;
  scp_rsp_s          word_nxt;

  assign rd_addr = ro_r ? ro_cs_r : cs_sel_r;

  scp_cfg_mem #(
    .W     (DATA_W),
    .DEPTH (CFG_DEPTH),
    .ONES  (CFG_ONES_SEL)
  ) u_cfg_mem (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_we     (cfg_write),
    .i_waddr  (rx_cmd.config_select_field),
    .i_wdata  (rx_cmd.data),
    .i_raddr  (rd_addr),
    .o_rdata  (mem_rd)
  );

  assign fail_stat = i_event_status[1] | (DATA_W'(cmd_err_r) << SPI_FAIL_BIT);

  // Interrupt selects return event status, the reserved select zero, the others the stored setting.
  assign sel_data =
    (rd_cs_q_r == CS_WAKE_IRQ)     ? i_event_status[0] :            // [RULE20]
    (rd_cs_q_r == CS_DEV_FAIL_IRQ) ? fail_stat :
    (rd_cs_q_r == CS_COM_FAIL_IRQ) ? i_event_status[2] :
    (rd_cs_q_r == CS_RESERVED)     ? '0 : mem_rd;

  assign fresh_word = '{frame_fault_flag:    1'b0,
                        wake_state:          wake_s,                // [RULE14]
                        mode_select_field:   mode_r,                // [RULE19]
                        config_select_field: cs_sel_r,
                        data:                sel_data};
  // A corrupted frame makes the next one repeat the last word.
  assign word_nxt = repeat_r ? {fault_r, last_out_r[14:0]}          // [RULE12] [RULE8]
                             : fresh_word;

  // ----------------------------------------------------------------------
  // Frame tracking and shifting
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_d_r <= 1'b0;
      csn_d_r  <= 1'b1;
      frame_r  <= FR_IDLE;
    end else begin
      sclk_d_r <= sclk_s;
      csn_d_r  <= csn_s;
      case (frame_r)
        FR_IDLE:  frame_r <= cs_fall ? FR_SHIFT : FR_IDLE;
        FR_SHIFT: frame_r <= cs_rise ? FR_IDLE : FR_SHIFT;
        default:  frame_r <= FR_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      fall_cnt_r <= '0;
      in_shift_r <= '0;
    end else if (cs_fall) begin
      fall_cnt_r <= '0;
    end else if (in_frame && sclk_fall) begin
      in_shift_r <= {in_shift_r[14:0], sdi_s};                      // [RULE5]
      if (fall_cnt_r != BIT_CNT_MAX) begin
        fall_cnt_r <= fall_cnt_r + 5'h1;                            // [RULE7]
      end
    end
  end

  // The output bit comes only from the response register.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      bit_idx_r <= BIT_IDX_FIRST;
      out_bit_r <= 1'b0;
    end else if (cs_fall) begin
      bit_idx_r <= BIT_IDX_FIRST;
      out_bit_r <= word_nxt[BIT_IDX_FIRST];                         // [RULE8] [RULE9]
    end else if (in_frame && sclk_rise) begin
      bit_idx_r <= nxt_idx;
      out_bit_r <= out_word_r[nxt_idx];                             // [RULE6]
    end
  end

  // A read access patches the data bits in flight, well before they leave.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_word_r <= '0;
    end else if (cs_fall) begin
      out_word_r <= word_nxt;                                       // [RULE1]
    end else if (ro_r && in_frame && rd_cs_q_r == ro_cs_r) begin
      out_word_r.data <= sel_data;                                  // [RULE18]
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ro_r      <= 1'b0;
      ro_cs_r   <= CS_WAKE_IRQ;
      rd_cs_q_r <= CS_WAKE_IRQ;
    end else begin
      rd_cs_q_r <= rd_addr;
      if (cs_fall) begin
        ro_r <= 1'b0;
      end else if (hdr_read) begin
        ro_r    <= 1'b1;
        ro_cs_r <= scp_cs_e'(in_shift_r[2:0]);
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      last_out_r <= '0;
      repeat_r   <= 1'b0;
      fault_r    <= 1'b0;
    end else if (frame_end) begin
      last_out_r <= out_word_r;
      repeat_r   <= ~accept;                                        // [RULE12]
      fault_r    <= ~len_ok;                                        // [RULE8]
    end
  end

  // ----------------------------------------------------------------------
  // Command application
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_r <= MODE_INIT;
    end else if (i_auto_mode_vld) begin
      mode_r <= i_auto_mode;                                        // [RULE21]
    end else if (accept && !is_read) begin
      mode_r <= rx_cmd.mode_select_field;                           // [RULE3] [RULE24]
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_sel_r  <= CS_WAKE_IRQ;
      cmd_r     <= '0;
      cmd_vld_r <= 1'b0;
      cfg_wr_r  <= 1'b0;
      wd_r      <= 1'b0;
    end else begin
      cmd_vld_r <= accept;
      cfg_wr_r  <= cfg_write;
      if (accept) begin
        cs_sel_r <= rx_cmd.config_select_field;
        cmd_r    <= rx_cmd;                                         // [RULE3]
        wd_r     <= rx_cmd.watchdog_toggle_bit;                     // [RULE13]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Command error flag and its interrupt
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmd_err_r <= 1'b0;
      fail_en_r <= 1'b1;                                            // [RULE23]
      irq_r     <= 1'b0;
    end else begin
      // A new corruption beats a read that clears in the same cycle.
      if (corrupt) begin
        cmd_err_r <= 1'b1;                                          // [RULE11]
      end else if (err_read) begin
        cmd_err_r <= 1'b0;                                          // [RULE22]
      end
      if (cfg_write && rx_cmd.config_select_field == CS_DEV_FAIL_IRQ) begin
        fail_en_r <= rx_cmd.data[SPI_FAIL_BIT];
      end
      irq_r <= (cmd_err_r | corrupt) & ~(err_read & ~corrupt) & fail_en_r; // [RULE11]
    end
  end

  assign o_serial_out          = out_bit_r;
  assign o_serial_out_oe       = in_frame;                          // [RULE4]
  assign o_cmd_vld             = cmd_vld_r;
  assign o_cfg_wr              = cfg_wr_r;
  assign o_cmd                 = cmd_r;
  assign o_watchdog_toggle_bit = wd_r;
  assign o_mode                = mode_r;
  assign o_cfg_sel             = cs_sel_r;
  assign o_cmd_err             = cmd_err_r;
  assign o_cmd_err_irq         = irq_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  property p_release_out;
    cs_rise |=> !o_serial_out_oe ##1 !o_serial_out_oe;
  endproperty
  a_release_out: assert property (p_release_out) else $error("output not released"); // [RULE4]

  property p_sample_fall;
    in_frame && sclk_fall && !cs_fall |=> in_shift_r[0] == $past(sdi_s);
  endproperty
  a_sample_fall: assert property (p_sample_fall) else $error("input bit not sampled"); // [RULE5]

  property p_len_drop;
    frame_end && fall_cnt_r != BIT_CNT_FULL |=> !o_cmd_vld && !o_cfg_wr;
  endproperty
  a_len_drop: assert property (p_len_drop) else $error("bad length accepted"); // [RULE7]

  property p_fault_first;
    cs_fall && fault_r && repeat_r |=> o_serial_out && o_serial_out_oe;
  endproperty
  a_fault_first: assert property (p_fault_first) else $error("fault flag missing"); // [RULE8]

  property p_err_set;
    corrupt |=> o_cmd_err ##1 (o_cmd_err_irq == fail_en_r);
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag not set"); // [RULE11]

  property p_repeat;
    cs_fall && repeat_r |=> out_word_r[14:0] == $past(last_out_r[14:0]);
  endproperty
  a_repeat: assert property (p_repeat) else $error("data not repeated"); // [RULE12]

  property p_restart_gate;
    accept && rx_cmd.mode_select_field == MODE_RESTART |-> mode_r == MODE_FLASH;
  endproperty
  a_restart_gate: assert property (p_restart_gate) else $error("restart accepted"); // [RULE15]

  property p_keep_mode;
    corrupt && !i_auto_mode_vld |=> $stable(o_mode) && !o_cfg_wr;
  endproperty
  a_keep_mode: assert property (p_keep_mode) else $error("mode changed"); // [RULE24]

  c_good_frame: cover property (accept && !is_read);
  c_read_frame: cover property (accept && is_read);
  c_bad_len: cover property (frame_end && !len_ok);
  c_forbidden: cover property (frame_end && len_ok && !req_ok);

endmodule : scp_cmd_port

// file: scp_host_model.sv
`timescale 1ns/1ps
module scp_host_model (
  input  wire logic i_mclk,
  output logic      o_chip_select_n,
  output logic      o_serial_clk,
  output logic      o_serial_in,
  input  wire logic i_serial_out,
  input  wire logic i_serial_out_oe
);
  localparam int HALF = 8;
  logic miso;
  logic miso_last = 1'b0;
  // A released line must not look like valid data, so it shows the inverse of its last bit.
  assign miso = i_serial_out_oe ? i_serial_out : ~miso_last;
  always @(posedge i_mclk) if (i_serial_out_oe === 1'b1) miso_last <= i_serial_out;
  initial begin
    o_chip_select_n = 1'b1;
    o_serial_clk = 1'b0;
    o_serial_in = 1'b1;
  end
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rsp);
    rsp = '0;
    @(posedge i_mclk);
    o_chip_select_n <= 1'b0;
    // The output bit is taken just before the rise that advances it; the input bit
    // changes with the rise so that it has settled long before the fall samples it.
    for (int i = 0; i < n; i++) begin
      repeat (HALF) @(posedge i_mclk);
      rsp = {rsp[14:0], miso};
      o_serial_clk <= 1'b1;
      o_serial_in  <= (i < 16) ? w[15-i] : 1'b0;
      repeat (HALF) @(posedge i_mclk);
      o_serial_clk <= 1'b0;
    end
    repeat (HALF) @(posedge i_mclk);
    o_chip_select_n <= 1'b1;
    o_serial_in <= ~o_serial_in;
    repeat (2 * HALF) @(posedge i_mclk);
  endtask : xfer
endmodule : scp_host_model

// file: scp_pkg.sv
package scp_pkg;

  // ----------------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------------
  localparam logic [4:0] BIT_CNT_FULL  = 5'h10;
  localparam logic [4:0] BIT_CNT_MAX   = 5'h1f;
  localparam logic [4:0] HDR_BITS      = 5'h07;
  localparam logic [3:0] BIT_IDX_FIRST = 4'hf;

  // ----------------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned CFG_DEPTH    = 8;
  localparam int unsigned SPI_FAIL_BIT = 4;
  localparam logic [7:0]  CFG_ONES_SEL = 8'h07;
  localparam logic [3:0]  PIN_RST      = 4'h4;

  typedef enum logic [2:0] {
    MODE_INIT     = 3'b000,
    MODE_RESTART  = 3'b001,
    MODE_FLASH    = 3'b010,
    MODE_NORMAL   = 3'b011,
    MODE_SLEEP    = 3'b100,
    MODE_STOP     = 3'b101,
    MODE_FAILSAFE = 3'b110,
    MODE_READ     = 3'b111
  } scp_mode_e;

  typedef enum logic [2:0] {
    CS_WAKE_IRQ     = 3'b000,
    CS_DEV_FAIL_IRQ = 3'b001,
    CS_COM_FAIL_IRQ = 3'b010,
    CS_RESERVED     = 3'b011,
    CS_DEV_CFG      = 3'b100,
    CS_COM_SETUP    = 3'b101,
    CS_WD_CFG       = 3'b110,
    CS_LIMP_DIAG    = 3'b111
  } scp_cs_e;

  typedef struct packed {
    logic              watchdog_toggle_bit;
    scp_mode_e         mode_select_field;
    scp_cs_e           config_select_field;
    logic              spare;
    logic [DATA_W-1:0] data;
  } scp_cmd_s;

  typedef struct packed {
    logic              frame_fault_flag;
    logic              wake_state;
    scp_mode_e         mode_select_field;
    scp_cs_e           config_select_field;
    logic [DATA_W-1:0] data;
  } scp_rsp_s;

  typedef logic [2:0][DATA_W-1:0] scp_stat_t;

endpackage : scp_pkg

// file: scp_sync.sv
`timescale 1ns/1ps
module scp_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         i_mclk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  if (W < 1) begin : g_bad_width
    $error("scp_sync needs a width of at least one");
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_r <= RST;
      o_sync <= RST;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule : scp_sync

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import scp_pkg::*;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        chip_select_n, serial_clk, serial_in, serial_out, serial_out_oe;
  logic        wake = 1'b1;
  logic        dev_mode = 1'b0;
  logic        auto_vld = 1'b0;
  scp_mode_e   auto_mode = MODE_INIT;
  scp_stat_t   stat = {8'h5c, 8'h2b, 8'hc3};
  logic        cmd_vld, cfg_wr, wd_bit, cmd_err, cmd_err_irq;
  scp_cmd_s    cmd;
  scp_mode_e   mode;
  scp_cs_e     cfg_sel;
  logic [15:0] rsp, prev;
  logic        wd = 1'b0;
  int          err_total = 0, num_checks = 0, n_vld = 0, n_wr = 0, wr0 = 0, cyc = 0;
  scp_mode_e   seq [5] = '{MODE_FLASH, MODE_RESTART, MODE_NORMAL, MODE_SLEEP, MODE_STOP};

  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    if (cmd_vld === 1'b1) n_vld <= n_vld + 1;
    if (cfg_wr === 1'b1) n_wr <= n_wr + 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      finish_test();
    end
  end

  scp_cmd_port u_dut (
    .i_mclk(mclk), .i_resetn(resetn), .i_chip_select_n(chip_select_n),
    .i_serial_clk(serial_clk), .i_serial_in(serial_in), .o_serial_out(serial_out),
    .o_serial_out_oe(serial_out_oe), .i_wake_input(wake), .i_sw_dev_mode(dev_mode),
    .i_auto_mode_vld(auto_vld), .i_auto_mode(auto_mode), .i_event_status(stat),
    .o_cmd_vld(cmd_vld), .o_cfg_wr(cfg_wr), .o_cmd(cmd), .o_watchdog_toggle_bit(wd_bit),
    .o_mode(mode), .o_cfg_sel(cfg_sel), .o_cmd_err(cmd_err), .o_cmd_err_irq(cmd_err_irq)
  );
  scp_host_model u_host (
    .i_mclk(mclk), .o_chip_select_n(chip_select_n), .o_serial_clk(serial_clk),
    .o_serial_in(serial_in), .i_serial_out(serial_out), .i_serial_out_oe(serial_out_oe)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic frame(input scp_mode_e m, input scp_cs_e c, input logic [7:0] d,
                       input int n, input logic ok);
    int v0;
    v0 = n_vld;
    wr0 = n_wr;
    prev = rsp;
    wd = ~wd;
    u_host.xfer({wd, m, c, 1'b0, d}, n, rsp);
    chk(16'(n_vld - v0), {15'h0, ok});
  endtask : frame

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(16'(mode), 16'(MODE_INIT));
    frame(MODE_NORMAL, CS_DEV_CFG, 8'h5a, 16, 1'b1);
    chk(cmd, {wd, MODE_NORMAL, CS_DEV_CFG, 1'b0, 8'h5a});
    chk(16'(n_wr - wr0), 16'h1);
    chk(16'(cfg_sel), 16'(CS_DEV_CFG));
    chk(16'(wd_bit), 16'(wd));
    chk(rsp[15:14], 2'b01);
    chk(16'(serial_out_oe), 16'h0);
    frame(MODE_READ, CS_DEV_CFG, 8'h00, 16, 1'b1);
    chk(rsp[7:0], 8'h5a);
    chk(16'(n_wr - wr0), 16'h0);
    chk(16'(mode), 16'(MODE_NORMAL));
    for (int c = 0; c < 4; c++) begin
      frame(MODE_READ, scp_cs_e'(c), 8'h00, 16, 1'b1);
      chk(rsp[7:0], (c < 3) ? stat[c] : 8'h00);
    end
    frame(MODE_RESTART, CS_RESERVED, 8'h00, 16, 1'b0);
    foreach (seq[i]) begin
      frame(seq[i], CS_RESERVED, 8'h00, 16, 1'b1);
      chk(16'(mode), 16'(seq[i]));
    end
    frame(MODE_FLASH, CS_WD_CFG, 8'h00, 16, 1'b0);
    chk(16'(mode), 16'(MODE_STOP));
    chk(16'(cfg_sel), 16'(CS_RESERVED));
    chk({cmd_err, cmd_err_irq}, 2'b11);
    frame(MODE_NORMAL, CS_RESERVED, 8'h00, 16, 1'b1);
    chk(rsp, {1'b0, prev[14:0]});
    frame(MODE_FAILSAFE, CS_RESERVED, 8'h00, 16, 1'b0);
    dev_mode <= 1'b1;
    frame(MODE_FAILSAFE, CS_RESERVED, 8'h00, 16, 1'b1);
    chk(16'(mode), 16'(MODE_FAILSAFE));
    dev_mode <= 1'b0;
    frame(MODE_INIT, CS_RESERVED, 8'h00, 16, 1'b0);
    frame(MODE_NORMAL, CS_DEV_CFG, 8'h11, 15, 1'b0);
    frame(MODE_READ, CS_DEV_CFG, 8'h00, 16, 1'b1);
    chk(rsp[15], 1'b1);
    frame(MODE_NORMAL, CS_DEV_CFG, 8'h22, 17, 1'b0);
    frame(MODE_READ, CS_DEV_CFG, 8'h00, 16, 1'b1);
    frame(MODE_READ, CS_DEV_CFG, 8'h00, 16, 1'b1);
    chk({rsp[15], rsp[7:0]}, 9'h05a);
    chk(16'(mode), 16'(MODE_FAILSAFE));
    frame(MODE_READ, CS_DEV_FAIL_IRQ, 8'h00, 16, 1'b1);
    chk(16'(rsp[4]), 16'h1);
    chk({cmd_err, cmd_err_irq}, 2'b00);
    frame(MODE_NORMAL, CS_DEV_FAIL_IRQ, 8'h00, 16, 1'b1);
    frame(MODE_INIT, CS_RESERVED, 8'h00, 16, 1'b0);
    chk({cmd_err, cmd_err_irq}, 2'b10);
    @(posedge mclk);
    auto_vld <= 1'b1;
    auto_mode <= MODE_RESTART;
    @(posedge mclk);
    auto_vld <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(16'(mode), 16'(MODE_RESTART));
    wake <= 1'b0;
    frame(MODE_READ, CS_WAKE_IRQ, 8'h00, 16, 1'b1);
    chk(rsp[15:14], 2'b01);
    frame(MODE_READ, CS_WAKE_IRQ, 8'h00, 16, 1'b1);
    chk(16'(rsp[14]), 16'h0);
    finish_test();
  end
endmodule : testbench
